// ### design/irq_vector_select.v
`timescale 1ns/1ns
`include "timer_irq_map.vh"
// Fixed-priority pick of the pending enabled source, lowest index first.
module irq_vector_select
(
    input wire [9:0] pending,
    output reg [3:0] vector
);
    integer i;

    always @*
    begin
        vector = `VEC_NONE;
        for (i = 9; i >= 0; i = i - 1)
        begin
            if (pending[i])
            begin
                vector = i[3:0] + 4'h1;
            end
        end
    end
endmodule

// ### design/timer_event_detect.v
`timescale 1ns/1ns
`include "timer_irq_map.vh"
// Turns one timer's raw signals into single-cycle flag set pulses.
module timer_event_detect
(
    input wire clk,
    input wire rst,
    input wire ce,
    input wire capture_pin,
    input wire capture_edge_rise,
    input wire timer_tick,
    input wire [15:0] counter,
    input wire [15:0] capture_value,
    input wire [15:0] cmp_a_value,
    input wire [15:0] cmp_b_value,
    input wire [15:0] cmp_c_value,
    input wire [3:0] waveform_mode_bits,
    input wire overflow,
    output reg set_capture,
    output reg set_cmp_a,
    output reg set_cmp_b,
    output reg set_cmp_c,
    output reg set_ovf
);
    reg pin_meta_q;
    reg pin_sync_q;
    reg pin_prev_q;
    reg [2:0] match_q;
    reg top_match_q;
    wire icr_top;
    wire pin_edge;

    assign icr_top = (waveform_mode_bits == `WGM_PWM_PFC_ICR) ||
        (waveform_mode_bits == `WGM_PWM_PC_ICR) ||
        (waveform_mode_bits == `WGM_CTC_ICR) ||
        (waveform_mode_bits == `WGM_FAST_ICR);
    assign pin_edge = capture_edge_rise ? (pin_sync_q & ~pin_prev_q)
        : (~pin_sync_q & pin_prev_q);

    always @(posedge clk)
    begin
        if (rst)
        begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            pin_prev_q <= 1'b0;
            match_q <= 3'h0;
            top_match_q <= 1'b0;
            set_capture <= 1'b0;
            set_cmp_a <= 1'b0;
            set_cmp_b <= 1'b0;
            set_cmp_c <= 1'b0;
            set_ovf <= 1'b0;
        end
        else if (ce)
        begin
            pin_meta_q <= capture_pin;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
            set_capture <= 1'b0;
            set_cmp_a <= 1'b0;
            set_cmp_b <= 1'b0;
            set_cmp_c <= 1'b0;
            set_ovf <= 1'b0;
            if (icr_top)
            begin
                set_capture <= timer_tick & top_match_q;
            end
            else
            begin
                set_capture <= pin_edge;
            end
            if (timer_tick)
            begin
                // Matches are latched on one tick and flagged on the next.
                match_q[0] <= (counter == cmp_a_value);
                match_q[1] <= (counter == cmp_b_value);
                match_q[2] <= (counter == cmp_c_value);
                top_match_q <= (counter == capture_value);
                set_cmp_a <= match_q[0];
                set_cmp_b <= match_q[1];
                set_cmp_c <= match_q[2];
                // The waveform generator qualifies overflow per mode, so
                // every mode passes it straight through here.
                set_ovf <= overflow;
            end
        end
    end
endmodule

// ### design/timer_irq_flag_mask_logic.v
`timescale 1ns/1ns
`include "timer_irq_map.vh"
// Summary of operation
// - Requests need the source flag, its enable bit and the global flag set.
// - Extended enable holds t3 cmp A 4, cmp B 3, ovf 2, cmp C 1, t1 cmp C 0.
// - Shared flags hold t1 capture at 5, cmp A at 4, cmp B at 3, ovf at 2.
// - Extended flags hold t3 cap 5, A 4, B 3, ovf 2, C 1 and t1 cmp C 0.
// - Unless the capture register is top, a capture flag sets on a detected edge at that timer's capture pin.
// - With the capture register as top, reaching top sets the capture flag.
// - A compare flag sets a timer cycle after the counter equals its value.
// - A forced compare strobe never sets a compare flag.
// - The overflow flag sets on each overflow the generator reports.
// - Taking a vector clears the matching flag.
// - Writing one to a flag bit clears that flag.
// - Extended enable bit 5 enables the timer 3 capture interrupt.
module timer_irq_flag_mask_logic
(
    input wire SYS_CLK,
    input wire RESET,
    input wire CLK_EN,
    input wire [4:0] WB_ADR_I,
    input wire [31:0] WB_DAT_I,
    input wire [3:0] WB_SEL_I,
    input wire WB_WE_I,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    input wire GLOBAL_IRQ_FLAG,
    input wire VECTOR_TAKEN,
    input wire [3:0] VECTOR_TAKEN_ID,
    input wire T1_CAPTURE_PIN,
    input wire T3_CAPTURE_PIN,
    input wire T1_TICK,
    input wire T3_TICK,
    input wire [15:0] T1_COUNTER,
    input wire [15:0] T3_COUNTER,
    input wire [15:0] T1_CAPTURE_VALUE,
    input wire [15:0] T3_CAPTURE_VALUE,
    input wire [15:0] T1_CMP_A_VALUE,
    input wire [15:0] T1_CMP_B_VALUE,
    input wire [15:0] T1_CMP_C_VALUE,
    input wire [15:0] T3_CMP_A_VALUE,
    input wire [15:0] T3_CMP_B_VALUE,
    input wire [15:0] T3_CMP_C_VALUE,
    input wire [3:0] T1_WAVEFORM_MODE_BITS,
    input wire [3:0] T3_WAVEFORM_MODE_BITS,
    input wire T1_OVERFLOW,
    input wire T3_OVERFLOW,
    output reg IRQ_REQUEST,
    output reg [3:0] IRQ_VECTOR,
    output reg IRQ_OUT
);
    reg [7:0] timer_irq_flags_q;
    reg [7:0] extended_timer_irq_flags_q;
    reg [7:0] timer_irq_enable_q;
    reg [7:0] ext_timer_irq_enable_reg_q;
    reg [1:0] cap_edge_q;
    reg [1:0] status_q;
    reg [1:0] status_en_q;
    reg [7:0] flags_d;
    reg [7:0] ext_d;
    reg [31:0] rdata_d;
    reg [9:0] taken;
    wire t1_cap;
    wire t1_a;
    wire t1_b;
    wire t1_c;
    wire t1_ov;
    wire t3_cap;
    wire t3_a;
    wire t3_b;
    wire t3_c;
    wire t3_ov;
    wire [9:0] flag_vec;
    wire [9:0] en_vec;
    wire [9:0] pending;
    wire [3:0] vector;
    wire access;
    wire wr;
    wire [7:0] wbyte;
    wire [1:0] ev;
    wire wr_flags;
    wire wr_ext_flags;
    wire wr_enable;
    wire wr_ext_enable;
    wire wr_ctrl;
    wire wr_status_clr;
    wire wr_status_en;

    assign access = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wr = access & WB_WE_I & WB_SEL_I[0];
    assign wbyte = WB_DAT_I[7:0];

    // One strobe per register, so a write reaches at most one of them.
    assign wr_flags = wr && (WB_ADR_I == `OFS_TIMER_IRQ_FLAGS);
    assign wr_ext_flags = wr && (WB_ADR_I == `OFS_EXT_TIMER_IRQ_FLAGS);
    assign wr_enable = wr && (WB_ADR_I == `OFS_TIMER_IRQ_ENABLE);
    assign wr_ext_enable = wr && (WB_ADR_I == `OFS_EXT_TIMER_IRQ_ENABLE);
    assign wr_ctrl = wr && (WB_ADR_I == `OFS_GLOBAL_CTRL);
    assign wr_status_clr = wr && (WB_ADR_I == `OFS_STATUS_CLR);
    assign wr_status_en = wr && (WB_ADR_I == `OFS_STATUS_EN);

    // Forced compare strobes are not inputs here, so they cannot set flags.
    timer_event_detect t1_events
    (
        .clk(SYS_CLK),
        .rst(RESET),
        .ce(CLK_EN),
        .capture_pin(T1_CAPTURE_PIN),
        .capture_edge_rise(cap_edge_q[0]),
        .timer_tick(T1_TICK),
        .counter(T1_COUNTER),
        .capture_value(T1_CAPTURE_VALUE),
        .cmp_a_value(T1_CMP_A_VALUE),
        .cmp_b_value(T1_CMP_B_VALUE),
        .cmp_c_value(T1_CMP_C_VALUE),
        .waveform_mode_bits(T1_WAVEFORM_MODE_BITS),
        .overflow(T1_OVERFLOW),
        .set_capture(t1_cap),
        .set_cmp_a(t1_a),
        .set_cmp_b(t1_b),
        .set_cmp_c(t1_c),
        .set_ovf(t1_ov)
    );

    timer_event_detect t3_events
    (
        .clk(SYS_CLK),
        .rst(RESET),
        .ce(CLK_EN),
        .capture_pin(T3_CAPTURE_PIN),
        .capture_edge_rise(cap_edge_q[1]),
        .timer_tick(T3_TICK),
        .counter(T3_COUNTER),
        .capture_value(T3_CAPTURE_VALUE),
        .cmp_a_value(T3_CMP_A_VALUE),
        .cmp_b_value(T3_CMP_B_VALUE),
        .cmp_c_value(T3_CMP_C_VALUE),
        .waveform_mode_bits(T3_WAVEFORM_MODE_BITS),
        .overflow(T3_OVERFLOW),
        .set_capture(t3_cap),
        .set_cmp_a(t3_a),
        .set_cmp_b(t3_b),
        .set_cmp_c(t3_c),
        .set_ovf(t3_ov)
    );

    // Flag vector in vector order: index i is vector i+1.
    assign flag_vec = {
        extended_timer_irq_flags_q[`BIT_T3_OVF],
        extended_timer_irq_flags_q[`BIT_T3_CMP_C],
        extended_timer_irq_flags_q[`BIT_T3_CMP_B],
        extended_timer_irq_flags_q[`BIT_T3_CMP_A],
        extended_timer_irq_flags_q[`BIT_T3_CAPTURE],
        extended_timer_irq_flags_q[`BIT_T1_CMP_C],
        timer_irq_flags_q[`BIT_T1_OVF],
        timer_irq_flags_q[`BIT_T1_CMP_B],
        timer_irq_flags_q[`BIT_T1_CMP_A],
        timer_irq_flags_q[`BIT_T1_CAPTURE]};
    assign en_vec = {
        ext_timer_irq_enable_reg_q[`BIT_T3_OVF],
        ext_timer_irq_enable_reg_q[`BIT_T3_CMP_C],
        ext_timer_irq_enable_reg_q[`BIT_T3_CMP_B],
        ext_timer_irq_enable_reg_q[`BIT_T3_CMP_A],
        ext_timer_irq_enable_reg_q[`BIT_T3_CAPTURE],
        ext_timer_irq_enable_reg_q[`BIT_T1_CMP_C],
        timer_irq_enable_q[`BIT_T1_OVF],
        timer_irq_enable_q[`BIT_T1_CMP_B],
        timer_irq_enable_q[`BIT_T1_CMP_A],
        timer_irq_enable_q[`BIT_T1_CAPTURE]};
    assign pending = flag_vec & en_vec & {10{GLOBAL_IRQ_FLAG}};

    irq_vector_select picker
    (
        .pending(pending),
        .vector(vector)
    );

    // Acknowledged vector, decoded one-hot.
    // Ids outside the source range decode to nothing and clear no flag.
    always @*
    begin
        taken = 10'h000;
        if (VECTOR_TAKEN && VECTOR_TAKEN_ID != `VEC_NONE &&
            VECTOR_TAKEN_ID <= `VEC_T3_OVF)
        begin
            taken[VECTOR_TAKEN_ID - 4'h1] = 1'b1;
        end
    end

    // Clears from software or vector come first; events then set, so a
    // coincident event is never lost.
    always @*
    begin
        flags_d = timer_irq_flags_q;
        ext_d = extended_timer_irq_flags_q;
        if (wr_flags)
        begin
            flags_d = flags_d & ~(wbyte & `MASK_FLAGS);
        end
        if (wr_ext_flags)
        begin
            // Bits 7:6 are ignored, whatever software writes there.
            ext_d = ext_d & ~(wbyte & `MASK_EXT);
        end
        flags_d[`BIT_T1_CAPTURE] = flags_d[`BIT_T1_CAPTURE] & ~taken[0];
        flags_d[`BIT_T1_CMP_A] = flags_d[`BIT_T1_CMP_A] & ~taken[1];
        flags_d[`BIT_T1_CMP_B] = flags_d[`BIT_T1_CMP_B] & ~taken[2];
        flags_d[`BIT_T1_OVF] = flags_d[`BIT_T1_OVF] & ~taken[3];
        ext_d[`BIT_T1_CMP_C] = ext_d[`BIT_T1_CMP_C] & ~taken[4];
        ext_d[`BIT_T3_CAPTURE] = ext_d[`BIT_T3_CAPTURE] & ~taken[5];
        ext_d[`BIT_T3_CMP_A] = ext_d[`BIT_T3_CMP_A] & ~taken[6];
        ext_d[`BIT_T3_CMP_B] = ext_d[`BIT_T3_CMP_B] & ~taken[7];
        ext_d[`BIT_T3_CMP_C] = ext_d[`BIT_T3_CMP_C] & ~taken[8];
        ext_d[`BIT_T3_OVF] = ext_d[`BIT_T3_OVF] & ~taken[9];
        flags_d[`BIT_T1_CAPTURE] = flags_d[`BIT_T1_CAPTURE] | t1_cap;
        flags_d[`BIT_T1_CMP_A] = flags_d[`BIT_T1_CMP_A] | t1_a;
        flags_d[`BIT_T1_CMP_B] = flags_d[`BIT_T1_CMP_B] | t1_b;
        flags_d[`BIT_T1_OVF] = flags_d[`BIT_T1_OVF] | t1_ov;
        ext_d[`BIT_T1_CMP_C] = ext_d[`BIT_T1_CMP_C] | t1_c;
        ext_d[`BIT_T3_CAPTURE] = ext_d[`BIT_T3_CAPTURE] | t3_cap;
        ext_d[`BIT_T3_CMP_A] = ext_d[`BIT_T3_CMP_A] | t3_a;
        ext_d[`BIT_T3_CMP_B] = ext_d[`BIT_T3_CMP_B] | t3_b;
        ext_d[`BIT_T3_CMP_C] = ext_d[`BIT_T3_CMP_C] | t3_c;
        ext_d[`BIT_T3_OVF] = ext_d[`BIT_T3_OVF] | t3_ov;
    end

    // Status events: bit 0 a vector request rose, bit 1 a vector was taken.
    assign ev = {VECTOR_TAKEN, (|pending) & ~IRQ_REQUEST};

    always @*
    begin
        rdata_d = 32'h0000_0000;
        case (WB_ADR_I)
            `OFS_TIMER_IRQ_FLAGS: rdata_d[7:0] = timer_irq_flags_q;
            `OFS_EXT_TIMER_IRQ_FLAGS:
                rdata_d[7:0] = extended_timer_irq_flags_q;
            `OFS_TIMER_IRQ_ENABLE: rdata_d[7:0] = timer_irq_enable_q;
            `OFS_EXT_TIMER_IRQ_ENABLE:
                rdata_d[7:0] = ext_timer_irq_enable_reg_q;
            `OFS_GLOBAL_CTRL: rdata_d[1:0] = cap_edge_q;
            `OFS_STATUS: rdata_d[1:0] = status_q;
            `OFS_STATUS_EN: rdata_d[1:0] = status_en_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            timer_irq_flags_q <= `RESET_REG8;
            extended_timer_irq_flags_q <= `RESET_REG8;
            timer_irq_enable_q <= `RESET_REG8;
            ext_timer_irq_enable_reg_q <= `RESET_REG8;
            cap_edge_q <= 2'h0;
            status_q <= 2'h0;
            status_en_q <= 2'h0;
            WB_DAT_O <= 32'h0000_0000;
            WB_ACK_O <= 1'b0;
            IRQ_REQUEST <= 1'b0;
            IRQ_VECTOR <= `VEC_NONE;
            IRQ_OUT <= 1'b0;
        end
        else if (CLK_EN)
        begin
            timer_irq_flags_q <= flags_d;
            extended_timer_irq_flags_q <= ext_d;
            WB_ACK_O <= access;
            WB_DAT_O <= (access & ~WB_WE_I) ? rdata_d : 32'h0000_0000;
            if (wr_enable)
            begin
                // Only timer 1 bits live here; other timers own the rest.
                timer_irq_enable_q <= wbyte & `MASK_FLAGS;
            end
            if (wr_ext_enable)
            begin
                ext_timer_irq_enable_reg_q <= wbyte & `MASK_EXT;
            end
            if (wr_ctrl)
            begin
                cap_edge_q <= wbyte[1:0];
            end
            if (wr_status_en)
            begin
                status_en_q <= wbyte[1:0];
            end
            if (wr_status_clr)
            begin
                status_q <= (status_q & ~wbyte[1:0]) | ev;
            end
            else
            begin
                status_q <= status_q | ev;
            end
            IRQ_REQUEST <= |pending;
            IRQ_VECTOR <= vector;
            // Registered, so the line follows a status change a cycle late.
            IRQ_OUT <= |(status_q & status_en_q);
        end
    end
endmodule

// ### design/timer_irq_map.vh
`ifndef TIMER_IRQ_MAP_VH
`define TIMER_IRQ_MAP_VH

// Word offsets on the register bus (byte addresses).
`define OFS_TIMER_IRQ_FLAGS 5'h00
`define OFS_EXT_TIMER_IRQ_FLAGS 5'h04
`define OFS_TIMER_IRQ_ENABLE 5'h08
`define OFS_EXT_TIMER_IRQ_ENABLE 5'h0c
`define OFS_GLOBAL_CTRL 5'h10
`define OFS_STATUS 5'h14
`define OFS_STATUS_CLR 5'h18
`define OFS_STATUS_EN 5'h1c

// Shared flag and enable register, timer 1 bits.
`define BIT_T1_CAPTURE 5
`define BIT_T1_CMP_A 4
`define BIT_T1_CMP_B 3
`define BIT_T1_OVF 2

// Extended flag and enable register bits.
`define BIT_T3_CAPTURE 5
`define BIT_T3_CMP_A 4
`define BIT_T3_CMP_B 3
`define BIT_T3_OVF 2
`define BIT_T3_CMP_C 1
`define BIT_T1_CMP_C 0

// Writable masks.
`define MASK_FLAGS 8'h3c
`define MASK_EXT 8'h3f

`define RESET_REG8 8'h00

// Waveform modes that use the capture register as counter top.
`define WGM_PWM_PFC_ICR 4'h8
`define WGM_PWM_PC_ICR 4'ha
`define WGM_CTC_ICR 4'hc
`define WGM_FAST_ICR 4'he

// Vector indices, one per source; 0 means none.
`define VEC_NONE 4'h0
`define VEC_T1_CAPTURE 4'h1
`define VEC_T1_CMP_A 4'h2
`define VEC_T1_CMP_B 4'h3
`define VEC_T1_OVF 4'h4
`define VEC_T1_CMP_C 4'h5
`define VEC_T3_CAPTURE 4'h6
`define VEC_T3_CMP_A 4'h7
`define VEC_T3_CMP_B 4'h8
`define VEC_T3_CMP_C 4'h9
`define VEC_T3_OVF 4'ha

`endif

// ### sim/cpu_irq_model.sv
`timescale 1ns/1ns
module cpu_irq_model
#(
    parameter LAT = 3
)
(
    input wire clk,
    input wire rst,
    input wire auto_take,
    input wire gie,
    input wire irq_request,
    input wire [3:0] irq_vector,
    output reg taken,
    output reg [3:0] taken_id
);
integer wait_q;
always @(posedge clk)
begin
    taken <= 1'b0;
    // The id is only qualified by taken, so it may look valid while idle.
    taken_id <= ~taken_id;
    if (rst)
    begin
        wait_q <= 0;
        taken_id <= 4'h0;
    end
    else if (wait_q > 0)
        wait_q <= wait_q - 1;
    else if (auto_take && gie && irq_request)
    begin
        taken <= 1'b1;
        taken_id <= irq_vector;
        // A stale request is still visible for two edges after a take.
        wait_q <= LAT + 2;
    end
end
endmodule

// ### sim/timer_irq_flag_mask_logic_sva.sv
`timescale 1ns/1ns
module timer_irq_check
(
    input wire SYS_CLK,
    input wire RESET,
    input wire CLK_EN,
    input wire [4:0] WB_ADR_I,
    input wire WB_WE_I,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire [31:0] WB_DAT_O,
    input wire WB_ACK_O,
    input wire GLOBAL_IRQ_FLAG,
    input wire IRQ_REQUEST,
    input wire [3:0] IRQ_VECTOR,
    input wire IRQ_OUT
);
default clocking cb @(posedge SYS_CLK);
endclocking
default disable iff (RESET || !CLK_EN);
wire rd = WB_ACK_O && !WB_WE_I;
sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
endsequence
sequence s_ans;
    WB_ACK_O ##1 !WB_ACK_O;
endsequence
AST_ACK_LATENCY: assert property (s_req |=> s_ans)
    else $error("ack not a single pulse one cycle after request");
AST_DATA_IDLE: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data not zero outside ack");
AST_RESERVED_ZERO: assert property (
    rd && WB_ADR_I < 5'h10 |-> WB_DAT_O[31:6] == 26'h0)
    else $error("upper register bits read nonzero");
AST_FLAG_LOW_ZERO: assert property (
    rd && (WB_ADR_I == 5'h00 || WB_ADR_I == 5'h08)
    |-> WB_DAT_O[1:0] == 2'h0)
    else $error("foreign timer bits read nonzero");
AST_REQ_GLOBAL: assert property (IRQ_REQUEST |-> $past(GLOBAL_IRQ_FLAG))
    else $error("request without global flag");
AST_REQ_VECTOR: assert property (IRQ_REQUEST |-> IRQ_VECTOR != 4'h0)
    else $error("request with no vector");
AST_GLOBAL_OFF: assert property ($fell(GLOBAL_IRQ_FLAG) |=> !IRQ_REQUEST)
    else $error("request kept after global flag fell");
AST_RESET_CLEAR: assert property (disable iff (1'b0)
    RESET |=> !IRQ_REQUEST && !IRQ_OUT && !WB_ACK_O
    && IRQ_VECTOR == 4'h0)
    else $error("outputs not cleared by reset");
endmodule
bind timer_irq_flag_mask_logic timer_irq_check u_timer_irq_check
(
    .SYS_CLK(SYS_CLK), .RESET(RESET), .CLK_EN(CLK_EN),
    .WB_ADR_I(WB_ADR_I), .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .GLOBAL_IRQ_FLAG(GLOBAL_IRQ_FLAG), .IRQ_REQUEST(IRQ_REQUEST),
    .IRQ_VECTOR(IRQ_VECTOR), .IRQ_OUT(IRQ_OUT)
);

// ### sim/timer_irq_flag_mask_logic_test.sv
`timescale 1ns/1ns
module timer_irq_flag_mask_logic_test;
reg clk = 1'b0;
reg rst = 1'b1;
reg cyc = 1'b0;
reg stb = 1'b0;
reg we = 1'b0;
reg [4:0] adr = 5'h00;
reg [31:0] wdat = 32'h0;
reg gie = 1'b0;
reg auto = 1'b0;
reg pin = 1'b0;
reg tick = 1'b0;
reg ovf = 1'b0;
reg [15:0] cnt = 16'h0;
reg [15:0] ca = 16'h1;
reg [15:0] cb = 16'h2;
reg [15:0] cc = 16'h3;
reg [15:0] cap = 16'h5;
reg [3:0] mode = 4'h0;
reg [23:0] ev = {4'h6, 4'h7, 4'h8, 4'ha, 4'h9, 4'h5};
reg [7:0] q;
wire [31:0] rdat;
wire ack;
wire req;
wire irq;
wire taken;
wire [3:0] vec;
wire [3:0] tid;
integer num_errors = 0;
integer checked = 0;
integer cycles = 0;
integer i;
always #50 clk = ~clk;
timer_irq_flag_mask_logic u_timer_irq_flag_mask_logic
(
    .SYS_CLK(clk), .RESET(rst), .CLK_EN(1'b1), .WB_ADR_I(adr),
    .WB_DAT_I(wdat), .WB_SEL_I(4'h1), .WB_WE_I(we), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .GLOBAL_IRQ_FLAG(gie), .VECTOR_TAKEN(taken), .VECTOR_TAKEN_ID(tid),
    .T1_CAPTURE_PIN(pin), .T3_CAPTURE_PIN(pin), .T1_TICK(tick),
    .T3_TICK(tick), .T1_COUNTER(cnt), .T3_COUNTER(cnt),
    .T1_CAPTURE_VALUE(cap), .T3_CAPTURE_VALUE(cap),
    .T1_CMP_A_VALUE(ca), .T1_CMP_B_VALUE(cb), .T1_CMP_C_VALUE(cc),
    .T3_CMP_A_VALUE(ca), .T3_CMP_B_VALUE(cb), .T3_CMP_C_VALUE(cc),
    .T1_WAVEFORM_MODE_BITS(mode), .T3_WAVEFORM_MODE_BITS(mode),
    .T1_OVERFLOW(ovf), .T3_OVERFLOW(ovf), .IRQ_REQUEST(req),
    .IRQ_VECTOR(vec), .IRQ_OUT(irq)
);
cpu_irq_model u_cpu_irq_model
(
    .clk(clk), .rst(rst), .auto_take(auto), .gie(gie),
    .irq_request(req), .irq_vector(vec), .taken(taken), .taken_id(tid)
);
task final_report;
begin
    if (num_errors == 0 && checked > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
end
endtask
task chk8(input [7:0] got, input [7:0] exp);
begin
    checked = checked + 1;
    if (got !== exp)
    begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
end
endtask
task wb(input [4:0] a, input w, input [7:0] d);
begin
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    we <= w;
    wdat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1)
        @(posedge clk);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
end
endtask
task rc(input [4:0] a, input [7:0] e);
begin
    wb(a, 1'b0, 8'h00);
    chk8(q, e);
end
endtask
task tk(input [15:0] c, input o);
begin
    @(posedge clk);
    cnt <= c;
    tick <= 1'b1;
    ovf <= o;
    @(posedge clk);
    tick <= 1'b0;
    ovf <= 1'b0;
end
endtask
task fire;
begin
    pin <= 1'b1;
    tk(16'h1, 1'b0);
    tk(16'h2, 1'b0);
    tk(16'h3, 1'b1);
    tk(16'h0, 1'b0);
    pin <= 1'b0;
    tk(16'h0, 1'b0);
    repeat (6) @(posedge clk);
end
endtask
task wait2;
begin
    repeat (2) @(posedge clk);
end
endtask
task t_reset;
begin
    rc(5'h00, 8'h00);
    rc(5'h04, 8'h00);
    rc(5'h08, 8'h00);
    rc(5'h0c, 8'h00);
    rc(5'h14, 8'h00);
    rc(5'h02, 8'h00);
end
endtask
task t_flags;
begin
    wb(5'h10, 1'b1, 8'h03);
    rc(5'h10, 8'h03);
    tk(16'h1, 1'b0);
    rc(5'h00, 8'h00);
    tk(16'h0, 1'b0);
    wait2;
    rc(5'h00, 8'h10);
    fire;
    rc(5'h00, 8'h3c);
    rc(5'h04, 8'h3f);
    wb(5'h00, 1'b1, 8'h00);
    rc(5'h00, 8'h3c);
    wb(5'h00, 1'b1, 8'h10);
    rc(5'h00, 8'h2c);
    wb(5'h00, 1'b1, 8'h2c);
    wb(5'h04, 1'b1, 8'h3f);
    rc(5'h00, 8'h00);
    rc(5'h04, 8'h00);
end
endtask
task t_top;
begin
    mode <= 4'hc;
    tk(16'h5, 1'b0);
    tk(16'h0, 1'b0);
    wait2;
    rc(5'h00, 8'h20);
    rc(5'h04, 8'h20);
    mode <= 4'h0;
    wb(5'h00, 1'b1, 8'h20);
    wb(5'h04, 1'b1, 8'h20);
    wb(5'h10, 1'b1, 8'h00);
    pin <= 1'b1;
    repeat (6) @(posedge clk);
    rc(5'h00, 8'h00);
    pin <= 1'b0;
    repeat (6) @(posedge clk);
    rc(5'h00, 8'h20);
    rc(5'h04, 8'h20);
    wb(5'h00, 1'b1, 8'h20);
    wb(5'h04, 1'b1, 8'h20);
end
endtask
task t_mask;
begin
    fire;
    gie <= 1'b1;
    for (i = 0; i < 6; i = i + 1)
    begin
        wb(5'h0c, 1'b1, 8'h01 << i);
        wait2;
        chk8({7'h0, req}, 8'h01);
        chk8({4'h0, vec}, {4'h0, ev[i*4+:4]});
    end
    wb(5'h0c, 1'b1, 8'h00);
    for (i = 2; i < 6; i = i + 1)
    begin
        wb(5'h08, 1'b1, 8'h01 << i);
        wait2;
        chk8({4'h0, vec}, 8'h06 - i[7:0]);
    end
    wb(5'h08, 1'b1, 8'h3c);
    wb(5'h0c, 1'b1, 8'h3f);
    gie <= 1'b0;
    wait2;
    chk8({7'h0, req}, 8'h00);
end
endtask
task t_take;
begin
    auto <= 1'b1;
    gie <= 1'b1;
    wait2;
    i = 0;
    while (req !== 1'b0 && i < 300)
    begin
        @(posedge clk);
        i = i + 1;
    end
    auto <= 1'b0;
    rc(5'h00, 8'h00);
    rc(5'h04, 8'h00);
    chk8({7'h0, req}, 8'h00);
end
endtask
task t_status;
begin
    rc(5'h14, 8'h03);
    wb(5'h1c, 1'b1, 8'h03);
    wait2;
    chk8({7'h0, irq}, 8'h01);
    wb(5'h1c, 1'b1, 8'h00);
    wait2;
    chk8({7'h0, irq}, 8'h00);
    wb(5'h1c, 1'b1, 8'h03);
    wb(5'h18, 1'b1, 8'h03);
    wait2;
    chk8({7'h0, irq}, 8'h00);
    rc(5'h14, 8'h00);
end
endtask
always @(posedge clk)
begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
        num_errors = num_errors + 1;
        final_report;
    end
end
initial
begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_flags;
    t_top;
    t_mask;
    t_take;
    t_status;
    final_report;
end
endmodule
